// *** rtl/tsp_pkg.sv ***
// Shared constants for the two-wire sensor slave port.
// Assumes a 200 MHz system clock and a separate conversion clock.
package tsp_pkg;

  // Clocking and timeout
  localparam longint SYS_FREQ_HZ  = 200_000_000;
  localparam longint TMO_MS       = 30;
  localparam longint MS_PER_S     = 1000;
  localparam int unsigned TMO_CYC_DEF = int'(TMO_MS * SYS_FREQ_HZ / MS_PER_S);
  localparam int     TMO_W        = 23;

  // Bus framing
  localparam logic [3:0] CNT_ACK   = 4'h8;
  localparam logic [3:0] CNT_END   = 4'h9;
  localparam logic [6:0] SLAVE_ADDR = 7'h4C;
  localparam logic [4:0] HS_CODE_PFX = 5'h01;

  // Pointer values
  localparam logic [7:0] PTR_LOCAL  = 8'h00;
  localparam logic [7:0] PTR_REMOTE = 8'h01;
  localparam logic [7:0] PTR_CFG1   = 8'h09;
  localparam logic [7:0] PTR_MFR    = 8'hFE;
  localparam logic [7:0] PTR_DEV    = 8'hFF;

  // Identity values are arbitrary
  localparam logic [7:0] MFR_ID = 8'hA5;
  localparam logic [7:0] DEV_ID = 8'h3C;

  // Configuration and result layout
  localparam logic [7:0] CFG1_RST   = 8'h00;
  localparam int         CFG_SD_BIT = 6;
  localparam int         RES_OPEN_BIT = 0;
  localparam int         RES_SUPPLY_INVALID_FLAG_BIT = 1;
  localparam int         RES_TEMP_LSB = 4;
  localparam logic [15:0] RES_RST   = 16'h0000;
  localparam logic [11:0] TEMP_SHORT = 12'hC00;

  typedef enum logic [2:0] {
    B_IDLE  = 3'b000,
    B_ADDR  = 3'b001,
    B_WRITE = 3'b010,
    B_READ  = 3'b011,
    B_SKIP  = 3'b100
  } tsp_bus_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_CONV = 2'b01,
    C_SEND = 2'b10
  } tsp_conv_t;

endpackage : tsp_pkg

// *** rtl/tsp_sync.sv ***
// Three-stage synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; output moves once stages two and three agree.
`timescale 1ns/1ps
module tsp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);

  logic [2:0] stg_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stg_q <= {3{RST_VAL}};
    end else begin
      stg_q <= {stg_q[1:0], din};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout <= RST_VAL;
    end else if (stg_q[1] == stg_q[2]) begin
      dout <= stg_q[2];
    end
  end

endmodule : tsp_sync

// *** rtl/tsp_slave.sv ***
// Two-wire slave port with conversion sequencer for a temperature monitor.
// Assumes an open-drain bus resolved outside; conversion side runs on adc_clk.
//
// Summary of operation
// [RULE1] Both lines high means bus idle
// [RULE2] SDA falling while SCL high starts
// [RULE3] SDA rising while SCL high stops
// [RULE4] Master ends with stop or repeated start
// [RULE5] No limit on bytes per transfer
// [RULE6] Receiver holds SDA low for acknowledge
// [RULE7] Master not-acknowledge ends read, release SDA
// [RULE8] Single-byte read: master leaves ack high
// [RULE9] Two-byte read: ack first, not second
// [RULE10] Master code unacknowledged, enters high-speed mode
// [RULE11] Master code followed by slave address
// [RULE12] High-speed mode held until stop
// [RULE13] Line low 30 ms resets interface
// [RULE14] Timeout releases bus, awaits new start
// [RULE15] Master keeps clock at least 1 kHz
// [RULE16] Shutdown bit powers down after conversion
// [RULE17] Shutdown clear means continuous conversions
// [RULE18] Open diode sets result bit 0
// [RULE19] Shorted input reports minus 64 degrees
// [RULE20] Invalid supply skips the conversion
// [RULE21] Invalid supply sets result bit 1
// [RULE22] Address byte: seven bits plus direction
// [RULE23] First write byte loads register pointer
// [RULE24] Pointer kept across reads
// [RULE25] All bytes sent MSB first
// [RULE26] Lines synchronised, start/stop registered events
// [RULE27] Timeout counts only low lines in transaction
`timescale 1ns/1ps
module tsp_slave
  import tsp_pkg::*;
#(
  parameter int unsigned TMO_CYCLES = TMO_CYC_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic             hs_mode,
  output logic             shutdown_request_bit,
  input  wire logic        adc_clk,
  input  wire logic        adc_done,
  input  wire logic [11:0] adc_temp,
  input  wire logic        diode_open,
  input  wire logic        diode_short,
  input  wire logic        supply_valid,
  output logic             adc_start,
  output logic             adc_chan,
  output logic             powered_down
);

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling and bus events
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  logic [1:0] pin_raw, pin_s;
  // Lines idle high, so the filters start high and no false edge follows reset
  assign pin_raw        = {sda_i, scl_i};
  assign {sda_s, scl_s} = pin_s;
  for (genvar gp = 0; gp < 2; gp++) begin : g_pin_sync
    tsp_sync #(.RST_VAL(1'b1)) u_sync (.clk(sys_clk), .rst_b(rst_b), .din(pin_raw[gp]), .dout(pin_s[gp]));
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s; // RULE26
      sda_p_q <= sda_s;
    end
  end

  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s; // RULE2
  assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s; // RULE3
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // Byte framing and bus state
  tsp_bus_t        st_q;
  logic [3:0]      cnt_q;
  logic [7:0]      sr_q;
  logic            mack_q;
  logic            first_q;
  logic            tmo_hit;
  logic            addr_hit, hs_code, rw_bit;
  logic            ack_slot, ack_done;

  assign addr_hit = (sr_q[7:1] == SLAVE_ADDR); // RULE22
  assign hs_code  = (sr_q[7:3] == HS_CODE_PFX);
  assign rw_bit   = sr_q[0];
  assign ack_slot = scl_fall & (cnt_q == CNT_ACK);
  assign ack_done = scl_fall & (cnt_q == CNT_END);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      sr_q   <= '0;
      mack_q <= 1'b0;
    end else if (start_ev || stop_ev || tmo_hit) begin
      cnt_q <= '0;
    end else if (scl_rise) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q < CNT_ACK) begin
        sr_q <= {sr_q[6:0], sda_s}; // RULE25
      end
      if (cnt_q == CNT_ACK) begin
        mack_q <= ~sda_s;
      end
    end else if (ack_done) begin
      cnt_q <= '0; // RULE5
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= B_IDLE;
      first_q <= 1'b0;
    end else if (tmo_hit || stop_ev) begin
      st_q <= B_IDLE; // RULE13 RULE3 RULE1
    end else if (start_ev) begin
      st_q <= B_ADDR; // RULE2
    end else if (ack_slot) begin
      if (st_q == B_ADDR && !addr_hit) begin
        st_q <= B_SKIP;
      end
      if (st_q == B_WRITE) begin
        first_q <= 1'b0;
      end
    end else if (ack_done) begin
      case (st_q)
        B_ADDR: begin
          st_q    <= rw_bit ? B_READ : B_WRITE; // RULE22
          first_q <= ~rw_bit;
        end
        B_READ: begin
          if (!mack_q) begin
            st_q <= B_SKIP; // RULE7 RULE8 RULE9
          end
        end
        default: st_q <= st_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and configuration
  logic [7:0] ptr_q;
  logic [7:0] cfg_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= '0;
      cfg_q <= CFG1_RST;
    end else if (ack_slot && st_q == B_WRITE) begin
      if (first_q) begin
        ptr_q <= sr_q; // RULE23
      end else if (ptr_q == PTR_CFG1) begin
        cfg_q <= sr_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shutdown_request_bit <= 1'b0;
    end else begin
      shutdown_request_bit <= cfg_q[CFG_SD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and SDA drive
  logic [15:0] loc_q, rem_q;
  logic [15:0] rd_word;
  logic [7:0]  rd_byte;
  logic [7:0]  tx_q;
  logic        drv_low_q;

  // Pointer is never advanced by reads
  always_comb begin
    case (ptr_q) // RULE24
      PTR_LOCAL:  rd_word = loc_q;
      PTR_REMOTE: rd_word = rem_q;
      PTR_CFG1:   rd_word = {cfg_q, 8'h00};
      PTR_MFR:    rd_word = {MFR_ID, 8'h00};
      PTR_DEV:    rd_word = {DEV_ID, 8'h00};
      default:    rd_word = '0;
    endcase
  end

  // First byte of a read is the high byte, later ones the low byte
  assign rd_byte = (st_q == B_READ) ? rd_word[7:0] : rd_word[15:8]; // RULE25

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_low_q <= 1'b0;
      tx_q      <= '0;
    end else if (tmo_hit || start_ev || stop_ev) begin
      drv_low_q <= 1'b0; // RULE14
    end else if (ack_slot) begin
      // Master code gets no acknowledge
      drv_low_q <= (st_q == B_ADDR && addr_hit) || (st_q == B_WRITE); // RULE6 RULE10
    end else if (ack_done) begin
      if ((st_q == B_ADDR && rw_bit) || (st_q == B_READ && mack_q)) begin
        tx_q      <= rd_byte;
        drv_low_q <= ~rd_byte[7];
      end else begin
        drv_low_q <= 1'b0; // RULE7
      end
    end else if (scl_fall && st_q == B_READ && cnt_q != '0 && cnt_q < CNT_ACK) begin
      tx_q      <= {tx_q[6:0], 1'b0};
      drv_low_q <= ~tx_q[6]; // RULE25
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_o    <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_o    <= 1'b0;
      sda_oe_n <= ~drv_low_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // High-speed mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_mode <= 1'b0;
    end else if (tmo_hit || stop_ev) begin
      hs_mode <= 1'b0; // RULE12
    end else if (ack_slot && st_q == B_ADDR && hs_code) begin
      hs_mode <= 1'b1; // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stuck-bus timeout
  logic [TMO_W-1:0] tmo_q;

  assign tmo_hit = (tmo_q >= TMO_W'(TMO_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tmo_q <= '0;
    end else if (st_q == B_IDLE || (scl_s && sda_s) || stop_ev || tmo_hit) begin
      tmo_q <= '0; // RULE27
    end else begin
      tmo_q <= tmo_q + 1'b1; // RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result capture from conversion side
  logic        req_q, req_s, ack_q, ack_s, req_p_q;
  logic [15:0] res_q;
  logic        res_chan_q;

  // Word is held stable by the sender until the ack toggle returns
  tsp_sync #(.RST_VAL(1'b0)) u_req_sync (.clk(sys_clk), .rst_b(rst_b), .din(req_q), .dout(req_s));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_p_q <= 1'b0;
      ack_q   <= 1'b0;
      loc_q   <= RES_RST;
      rem_q   <= RES_RST;
    end else begin
      req_p_q <= req_s;
      if (req_s != req_p_q) begin
        ack_q <= req_s;
        if (res_chan_q) begin
          rem_q <= res_q;
        end else begin
          loc_q <= res_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer on adc_clk
  tsp_conv_t cst_q;
  logic      sd_s, open_s, short_s, sup_s;
  logic      open_seen_q, supply_invalid_flag_seen_q;

  logic [4:0] adc_raw, adc_s;

  // Supply counts as invalid until its filter has settled
  assign adc_raw                               = {ack_q, supply_valid, diode_short, diode_open, shutdown_request_bit};
  assign {ack_s, sup_s, short_s, open_s, sd_s} = adc_s;
  for (genvar ga = 0; ga < 5; ga++) begin : g_adc_sync
    tsp_sync #(.RST_VAL(1'b0)) u_sync (.clk(adc_clk), .rst_b(rst_b), .din(adc_raw[ga]), .dout(adc_s[ga]));
  end

  always_ff @(posedge adc_clk or negedge rst_b) begin
    if (!rst_b) begin
      cst_q        <= C_IDLE;
      adc_start    <= 1'b0;
      adc_chan     <= 1'b0;
      powered_down <= 1'b0;
      req_q        <= 1'b0;
      res_q        <= RES_RST;
      res_chan_q   <= 1'b0;
      open_seen_q  <= 1'b0;
      supply_invalid_flag_seen_q  <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      case (cst_q)
        C_IDLE: begin
          // Shutdown only takes effect between conversions
          powered_down <= sd_s; // RULE16
          open_seen_q  <= 1'b0;
          supply_invalid_flag_seen_q  <= 1'b0;
          if (!sd_s) begin
            if (sup_s) begin
              adc_start <= 1'b1; // RULE17
              cst_q     <= C_CONV;
            end else begin
              res_q                <= RES_RST; // RULE20
              res_q[RES_SUPPLY_INVALID_FLAG_BIT]  <= 1'b1; // RULE21
              res_chan_q           <= adc_chan;
              req_q                <= ~req_q;
              cst_q                <= C_SEND;
            end
          end
        end
        C_CONV: begin
          open_seen_q <= open_seen_q | open_s;
          supply_invalid_flag_seen_q <= supply_invalid_flag_seen_q | ~sup_s;
          if (adc_done) begin
            res_q <= '0;
            if (short_s) begin
              res_q[15:RES_TEMP_LSB] <= TEMP_SHORT; // RULE19
            end else begin
              res_q[15:RES_TEMP_LSB] <= adc_temp;
            end
            res_q[RES_OPEN_BIT] <= open_seen_q | open_s; // RULE18
            res_q[RES_SUPPLY_INVALID_FLAG_BIT] <= supply_invalid_flag_seen_q | ~sup_s; // RULE21
            res_chan_q          <= adc_chan;
            req_q               <= ~req_q;
            cst_q               <= C_SEND;
          end
        end
        C_SEND: begin
          if (ack_s == req_q) begin
            adc_chan <= ~adc_chan;
            cst_q    <= C_IDLE;
          end
        end
        default: begin
          cst_q <= C_IDLE;
        end
      endcase
    end
  end

endmodule : tsp_slave

// *** bench/tsp_asserts.sv ***
// Pin-level checker for the two-wire slave port.
// Assumes it is bound into tsp_slave; TMO_CYCLES follows the instance.
`timescale 1ns/1ps
module tsp_checker #(
  parameter int unsigned TMO_CYCLES = 2000
) (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  input wire logic        hs_mode,
  input wire logic        shutdown_request_bit,
  input wire logic        adc_clk,
  input wire logic        adc_done,
  input wire logic [11:0] adc_temp,
  input wire logic        diode_open,
  input wire logic        diode_short,
  input wire logic        supply_valid,
  input wire logic        adc_start,
  input wire logic        adc_chan,
  input wire logic        powered_down
);
  // Cycles since both lines were last high, saturating
  int unsigned low_cnt_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= '0;
    end else if (scl_i && sda_i) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q < TMO_CYCLES + 500) begin
      low_cnt_q <= low_cnt_q + 32'h1;
    end
  end
  ////////////////////////////////////////
  sequence s_hs_entry;
    $rose(hs_mode);
  endsequence
  sequence s_released8;
    sda_oe_n [*8];
  endsequence
  a_drive_low: assert property (@(posedge sys_clk) disable iff (!rst_b) !sda_oe_n |-> !sda_o)
    else $error("driven data not low");
  a_oe_steady_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    scl_i && $past(scl_i) |-> $stable(sda_oe_n)) else $error("data changed while clock high");
  a_hs_no_ack: assert property (@(posedge sys_clk) disable iff (!rst_b) s_hs_entry |-> s_released8)
    else $error("master code acknowledged");
  a_hs_held: assert property (@(posedge sys_clk) disable iff (!rst_b)
    hs_mode && low_cnt_q < TMO_CYCLES && !(scl_i && sda_i) |=> hs_mode) else $error("fast mode too early");
  a_tmo_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
    low_cnt_q == TMO_CYCLES + 100 |-> sda_oe_n && !hs_mode) else $error("stuck bus not released");
  a_sd_when_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $changed(shutdown_request_bit) |-> !scl_i) else $error("config changed off the bus");
  a_start_pulse: assert property (@(posedge adc_clk) disable iff (!rst_b) adc_start |=> !adc_start)
    else $error("start longer than a cycle");
  a_down_no_start: assert property (@(posedge adc_clk) disable iff (!rst_b) powered_down |-> !adc_start)
    else $error("start while powered down");
  a_supply_skip: assert property (@(posedge adc_clk) disable iff (!rst_b)
    !supply_valid [*6] |-> !adc_start) else $error("start on bad supply");
endmodule : tsp_checker

// *** bench/tsp_master.sv ***
// Two-wire bus master model; owns the clock line.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module tsp_master #(
  parameter int Q = 10
) (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  ////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : w
  // Data moves only while the clock is low; 4*Q cycles a bit
  task automatic bit_x(input logic b, output logic r);
    w(Q);
    sda_m <= b;
    w(Q);
    scl <= 1'b1;
    w(2 * Q);
    r = sda;
    scl <= 1'b0;
  endtask : bit_x
  task automatic start();
    w(Q);
    sda_m <= 1'b1;
    w(Q);
    scl <= 1'b1;
    w(Q);
    sda_m <= 1'b0;
    w(Q);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    w(Q);
    sda_m <= 1'b0;
    w(Q);
    scl <= 1'b1;
    w(Q);
    sda_m <= 1'b1;
    w(2 * Q);
  endtask : stop
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : put
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, r);
  endtask : get
endmodule : tsp_master

// *** bench/test_two_wire_sensor_slave_port.sv ***
// Self-checking bench for the two-wire slave port.
// Assumes tsp_master on the bus and a converter model below.
`timescale 1ns/1ps
module test_two_wire_sensor_slave_port;
  import tsp_pkg::*;
  localparam int unsigned TMO = 2000;
  localparam logic [7:0]  WR  = {SLAVE_ADDR, 1'b0};
  localparam logic [7:0]  RD  = {SLAVE_ADDR, 1'b1};
  typedef struct packed {logic [7:0] p; logic [15:0] w;} tsp_row_t;
  logic        sys_clk = 1'b0;
  logic        adc_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        scl, sda_m, sda, sda_o, sda_oe_n, hs_mode, shutdown_request_bit;
  logic        adc_done = 1'b0;
  logic [11:0] adc_temp = 12'h000;
  logic        diode_open = 1'b0;
  logic        diode_short = 1'b0;
  logic        supply_valid = 1'b1;
  logic        adc_start, adc_chan, powered_down, a;
  logic [7:0]  hi, lo;
  int          bad_count, samples_checked, cv;
  int unsigned cyc;
  tsp_row_t    rows [6] = '{'{PTR_LOCAL, 16'h1900}, '{PTR_REMOTE, 16'h3A50}, '{8'h42, 16'h0000},
    '{PTR_CFG1, {CFG1_RST, 8'h00}}, '{PTR_MFR, {MFR_ID, 8'h00}}, '{PTR_DEV, {DEV_ID, 8'h00}}};
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    #1.3;
    forever #40 adc_clk = ~adc_clk;
  end
  // Open drain: device can only pull low
  assign sda = sda_m & (sda_oe_n | sda_o);
  tsp_master m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  tsp_slave #(.TMO_CYCLES(TMO)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .hs_mode(hs_mode), .shutdown_request_bit(shutdown_request_bit),
    .adc_clk(adc_clk), .adc_done(adc_done), .adc_temp(adc_temp), .diode_open(diode_open),
    .diode_short(diode_short), .supply_valid(supply_valid), .adc_start(adc_start),
    .adc_chan(adc_chan), .powered_down(powered_down));
  always @(posedge adc_clk) begin
    adc_done <= 1'b0;
    if (adc_start) begin
      cv <= 4;
    end else if (cv > 0) begin
      cv <= cv - 1;
      adc_done <= (cv == 1);
      adc_temp <= adc_chan ? 12'h3A5 : 12'h190;
    end
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic send(input logic [7:0] q[$]);
    m.start();
    foreach (q[i]) begin
      m.put(q[i], a);
      check("write ack", 16'(a), 16'h1);
    end
  endtask : send
  task automatic rd(input logic two);
    m.start();
    m.put(RD, a);
    check("read ack", 16'(a), 16'h1);
    m.get(!two, hi);
    if (two) m.get(1'b1, lo);
    m.w(8);
    check("released", 16'(sda_oe_n), 16'h1);
    m.stop();
  endtask : rd
  task automatic conv(input int n);
    logic c;
    int   t;
    repeat (n) begin
      c = adc_chan;
      t = 0;
      while (adc_chan === c && t < 4000) begin
        @(posedge sys_clk);
        t++;
      end
      check("conversion", 16'(t < 4000), 16'h1);
    end
  endtask : conv
  task automatic until_pd(input logic v);
    int t;
    t = 0;
    while (powered_down !== v && t < 4000) begin
      @(posedge sys_clk);
      t++;
    end
    check("power state", 16'(powered_down), 16'(v));
  endtask : until_pd
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge adc_clk);
    check("reset", 16'({sda_oe_n, hs_mode, shutdown_request_bit, adc_start, adc_chan, powered_down}), 16'h0020);
    check("data value", 16'(sda_o), 16'h0);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    conv(2);
    foreach (rows[i]) begin
      send('{WR, rows[i].p});
      m.stop();
      rd(1'b1);
      check("word", {hi, lo}, rows[i].w);
    end
    rd(1'b0);
    check("repeat read", 16'(hi), 16'(DEV_ID));
    $display("table and repeat read done");
    m.start();
    m.put(8'h08, a);
    check("master code", 16'({a, hs_mode}), 16'h1);
    m.start();
    m.put(RD, a);
    m.w(20);
    check("device drives", 16'(sda_oe_n), 16'h0);
    m.w(TMO + 200);
    check("timeout", 16'({sda_oe_n, hs_mode}), 16'h2);
    m.stop();
    rd(1'b0);
    check("after timeout", 16'(hi), 16'(DEV_ID));
    m.start();
    m.put(8'h9A, a);
    check("foreign addr", 16'(a), 16'h0);
    m.stop();
    $display("timeout and address done");
    m.start();
    m.put(8'h08, a);
    send('{WR, PTR_CFG1, 8'h40, 8'h00, 8'h40});
    check("hs held", 16'(hs_mode), 16'h1);
    m.stop();
    m.w(10);
    check("hs off, shutdown", 16'({hs_mode, shutdown_request_bit}), 16'h1);
    until_pd(1'b1);
    send('{WR, PTR_CFG1, 8'h00});
    m.stop();
    until_pd(1'b0);
    $display("high speed and shutdown done");
    diode_open <= 1'b1;
    conv(3);
    send('{WR, PTR_REMOTE});
    m.stop();
    rd(1'b1);
    check("open flag", 16'(lo[0]), 16'h1);
    diode_open <= 1'b0;
    diode_short <= 1'b1;
    conv(3);
    rd(1'b1);
    check("short value", {hi, lo}, 16'hC000);
    diode_short <= 1'b0;
    supply_valid <= 1'b0;
    conv(3);
    send('{WR, PTR_LOCAL});
    m.stop();
    rd(1'b1);
    check("supply flag", {hi, lo}, 16'h0002);
    supply_valid <= 1'b1;
    $display("fault flags done");
    conclude();
  end
endmodule : test_two_wire_sensor_slave_port

bind tsp_slave tsp_checker #(.TMO_CYCLES(TMO_CYCLES)) chk (.sys_clk(sys_clk), .rst_b(rst_b), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .hs_mode(hs_mode),
  .shutdown_request_bit(shutdown_request_bit), .adc_clk(adc_clk), .adc_done(adc_done), .adc_temp(adc_temp),
  .diode_open(diode_open), .diode_short(diode_short), .supply_valid(supply_valid), .adc_start(adc_start),
  .adc_chan(adc_chan), .powered_down(powered_down));
